// [rtl/reset_init_cfg.svh]
// Purpose: constants for the reset and initialization block
// Assumes: 16-bit registers, byte-addressed register port, 250 MHz clock
// Notes: all offsets are byte addresses on the register port
`ifndef RESET_INIT_CFG_SVH
`define RESET_INIT_CFG_SVH

// register port offsets
`define RIS_OFS_BASE 8'h00
`define RIS_OFS_RELOC 8'hfe
`define RIS_OFS_RELEASE 8'hf4

// reset values
`define RIS_RST_ZERO 16'h0000
`define RIS_RST_FLAGS 16'hf002
`define RIS_RST_CODE_SEG 16'hffff
`define RIS_RST_RELOC 16'h20ff
`define RIS_RST_UPPER_SEL 16'hf03b
`define RIS_RST_DIR_HI 16'hffff
`define RIS_RST_DIR_LO 16'hfc0f
`define RIS_RST_ASYNC_INT 16'h001f
`define RIS_RST_SRC_INT 16'h000f
`define RIS_RST_PRI_THR 16'h0007
`define RIS_RST_INT_MASK 16'h07fd
`define RIS_RST_DMA_CH 16'hfff9

// block relocation fields
`define RIS_RELOC_SLAVE_BIT 14
`define RIS_RELOC_MEM_BIT 12
`define RIS_RELOC_BASE_MSB 11
`define RIS_RELOC_BASE_LSB 0

// upper memory select fields
`define RIS_UPPER_RDY_BIT 2
`define RIS_UPPER_WAIT_MSB 1
`define RIS_UPPER_WAIT_LSB 0

// internal interval before the first fetch
`define RIS_CLK_MHZ 250
`define RIS_INIT_INTERVAL_NS 64
`define RIS_INIT_CYCLES ((`RIS_INIT_INTERVAL_NS * `RIS_CLK_MHZ + 999) / 1000)

`endif

// [rtl/ris_pkg.sv]
// Purpose: types shared by the reset and initialization block
// Assumes: nothing beyond the cfg header
// Notes: register index order sets the offset map
package ris_pkg;

	typedef enum logic [5:0] {
		RI_FLAGS, RI_IP, RI_CODE_SEG, RI_DATA_SEG, RI_EXTRA_SEG, RI_STACK_SEG,
		RI_REFRESH_PART, RI_REFRESH_EN, RI_UPPER_SEL, RI_LOWER_SEL,
		RI_ASYNC_CTL, RI_GPIO_DIR_HI, RI_GPIO_FN_HI, RI_GPIO_DIR_LO, RI_GPIO_FN_LO,
		RI_ASYNC_INT, RI_WDOG_INT, RI_EXT4_INT, RI_EXT3_INT, RI_EXT2_INT,
		RI_EXT1_INT, RI_EXT0_INT, RI_DMA1_INT, RI_DMA0_INT, RI_TIMER_INT,
		RI_IN_SERVICE, RI_PRI_THR, RI_INT_MASK, RI_SYNC_CTL, RI_SYNC_STAT,
		RI_DMA1_CH, RI_DMA0_CH, RI_RELOC, RI_COUNT
	} reg_idx_t;

	typedef enum logic [2:0] {
		ST_HOLD = 3'b001,
		ST_WAIT = 3'b010,
		ST_RUN = 3'b100
	} init_state_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic [15:0] status_word;
		logic [15:0] code_segment;
		logic [15:0] instruction_pointer;
		logic [15:0] data_segment;
		logic [15:0] extra_segment;
		logic [15:0] stack_segment;
	} cpu_state_t;

	typedef struct packed {
		logic [19:0] block_base;
		logic block_in_memory;
		logic int_slave_mode;
		logic upper_ready_ignored;
		logic [1:0] upper_wait_states;
	} map_cfg_t;

endpackage : ris_pkg

// [rtl/pin_sync.sv]
// Purpose: two-flop synchroniser for the chip init pin
// Assumes: pin is asynchronous to i_clk
// Notes: resets to the asserted level so the core stays held
module pin_sync (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// pin and synchronised level
	input wire logic i_pin_n,
	output logic o_level_n
);
	logic meta_q;
	logic sync_q;

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			meta_q <= 1'b0;
			sync_q <= 1'b0;
		end else begin
			meta_q <= i_pin_n;
			sync_q <= meta_q;
		end
	end

	assign o_level_n = sync_q;
endmodule : pin_sync

// [rtl/init_interval.sv]
// Purpose: counts the internal interval after init release
// Assumes: i_hold high restarts the count
// Notes: o_done stays high until the next hold
module init_interval #(
	parameter int CYCLES = 16
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// control
	input wire logic i_hold,
	output logic o_done
);
	localparam int CW = $clog2(CYCLES + 1);

	logic [CW-1:0] cnt_q;
	logic [CW-1:0] cnt_d;

	if (CYCLES < 1) begin : g_chk
		$error("init_interval: CYCLES must be at least 1");
	end

	assign o_done = (cnt_q == CW'(CYCLES));
	assign cnt_d = o_done ? cnt_q : cnt_q + CW'(1);

	always_ff @(posedge i_clk) begin
		if (i_sys_rst || i_hold) begin
			cnt_q <= '0;
		end else begin
			cnt_q <= cnt_d;
		end
	end
endmodule : init_interval

// [rtl/reset_init_state.sv]
// Purpose: chip init sequencing and reset values of the control registers
// Assumes: chip init pin is asynchronous and active low; port master on i_clk
// Notes: registers with no defined reset value keep whatever they held
//
// Operation
// - a low chip init pin starts the initialization sequence
// - while init is held: no fetch, no execution, no local bus cycles; o_fetch_start can still pulse one cycle if init asserts on its issuing edge
// - after release an internal interval passes before the first fetch
// - code segment FFFFh and pointer 0000h, first fetch from FFFF0h
// - status word loads F002h, maskable interrupts disabled
// - data, extra and stack segments clear to 0000h
// - release level shows revision in upper byte, lower byte undefined
// - block relocation loads 20FFh: block at FF00h I/O, master mode
// - refresh base partition clears to 0000h
// - refresh enable control clears to 0000h
// - upper memory select loads F03Bh
// - async port control clears to 0000h
// - gpio directions FFFFh and FC0Fh, gpio functions 0000h
// - async port int ctl 001Fh, watchdog int ctl 000Fh
// - five external interrupt controls load 000Fh
// - both dma int controls and timer int control load 000Fh
// - in-service clears to 0000h, priority threshold loads 0007h
// - interrupt mask loads 07FDh
// - sync serial control and status clear to 0000h
// - both dma channel controls load FFF9h
// - registers with no reset value keep their contents
//
// The implementer's own choices: strobed register access and the address map.
`include "reset_init_cfg.svh"

module reset_init_state #(
	parameter int INIT_CYCLES = `RIS_INIT_CYCLES,
	// arbitrary revision code
	parameter logic [7:0] REVISION = 8'h5a
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// chip init pin, active low
	input wire logic i_chip_init_pin_n,
	// register port
	input ris_pkg::reg_req_t i_req,
	output logic [15:0] o_rdata,
	// execution control
	output logic o_run,
	output logic o_bus_en,
	output logic o_fetch_start,
	output logic [19:0] o_fetch_addr,
	// register state seen by the core and peripherals
	output ris_pkg::cpu_state_t o_cpu,
	output ris_pkg::map_cfg_t o_map,
	output logic [15:0] o_gpio_direction_hi,
	output logic [15:0] o_gpio_direction_lo,
	output logic [15:0] o_gpio_function_hi,
	output logic [15:0] o_gpio_function_lo,
	output logic [15:0] o_int_mask_bits,
	output logic [15:0] o_priority_threshold
);
	import ris_pkg::*;

	localparam int NREG = int'(RI_COUNT);

	if (INIT_CYCLES < 1) begin : g_chk
		$error("reset_init_state: INIT_CYCLES must be at least 1");
	end

	// the stored word map must stay clear of the release level word
	if (2 * NREG > int'(`RIS_OFS_RELEASE)) begin : g_map_chk
		$error("reset_init_state: register map overlaps the release level");
	end

	// reset value of each stored register
	function automatic logic [15:0] reset_val(input reg_idx_t idx);
		logic [15:0] v;
		v = `RIS_RST_ZERO;
		unique case (idx)
			// core state
			RI_FLAGS: v = `RIS_RST_FLAGS;
			RI_IP: v = `RIS_RST_ZERO;
			RI_CODE_SEG: v = `RIS_RST_CODE_SEG;
			RI_DATA_SEG: v = `RIS_RST_ZERO;
			RI_EXTRA_SEG: v = `RIS_RST_ZERO;
			RI_STACK_SEG: v = `RIS_RST_ZERO;
			// refresh, chip select and async port
			RI_REFRESH_PART: v = `RIS_RST_ZERO;
			RI_REFRESH_EN: v = `RIS_RST_ZERO;
			RI_UPPER_SEL: v = `RIS_RST_UPPER_SEL;
			RI_ASYNC_CTL: v = `RIS_RST_ZERO;
			// gpio
			RI_GPIO_DIR_HI: v = `RIS_RST_DIR_HI;
			RI_GPIO_FN_HI: v = `RIS_RST_ZERO;
			RI_GPIO_DIR_LO: v = `RIS_RST_DIR_LO;
			RI_GPIO_FN_LO: v = `RIS_RST_ZERO;
			// interrupt controls
			RI_ASYNC_INT: v = `RIS_RST_ASYNC_INT;
			RI_WDOG_INT: v = `RIS_RST_SRC_INT;
			RI_EXT4_INT: v = `RIS_RST_SRC_INT;
			RI_EXT3_INT: v = `RIS_RST_SRC_INT;
			RI_EXT2_INT: v = `RIS_RST_SRC_INT;
			RI_EXT1_INT: v = `RIS_RST_SRC_INT;
			RI_EXT0_INT: v = `RIS_RST_SRC_INT;
			RI_DMA1_INT: v = `RIS_RST_SRC_INT;
			RI_DMA0_INT: v = `RIS_RST_SRC_INT;
			RI_TIMER_INT: v = `RIS_RST_SRC_INT;
			RI_IN_SERVICE: v = `RIS_RST_ZERO;
			RI_PRI_THR: v = `RIS_RST_PRI_THR;
			RI_INT_MASK: v = `RIS_RST_INT_MASK;
			// sync serial, dma channels and relocation
			RI_SYNC_CTL: v = `RIS_RST_ZERO;
			RI_SYNC_STAT: v = `RIS_RST_ZERO;
			RI_DMA1_CH: v = `RIS_RST_DMA_CH;
			RI_DMA0_CH: v = `RIS_RST_DMA_CH;
			RI_RELOC: v = `RIS_RST_RELOC;
			// lower select is never loaded, see has_reset
			default: v = `RIS_RST_ZERO;
		endcase
		return v;
	endfunction : reset_val

	// lower memory select has no reset value and is left alone
	function automatic logic has_reset(input reg_idx_t idx);
		return idx != RI_LOWER_SEL;
	endfunction : has_reset

	// segment:offset to a 20-bit physical address
	function automatic logic [19:0] phys_addr(
		input logic [15:0] seg,
		input logic [15:0] off
	);
		return {seg, 4'h0} + {4'h0, off};
	endfunction : phys_addr

	// synchronised pin and interval
	logic init_n;
	logic interval_done;
	logic init_hold;

	// sequencing state
	init_state_t state_q;
	init_state_t state_d;
	logic fetch_start_q;
	logic [19:0] fetch_addr_q;
	logic fetch_issued_q;
	logic in_wait;
	logic in_run;
	logic [19:0] boot_addr;
	logic [15:0] reloc_word;
	logic [15:0] upper_sel_word;
	logic [NREG-1:0] load_rst;
	logic [NREG-1:0] load_wr;

	// register storage
	logic [15:0] regs_q [NREG];
	logic [15:0] rdata_q;
	logic [15:0] rdata_d;

	// address decode
	logic [7:0] rel_addr;
	logic in_range;
	logic hit_reloc;
	logic hit_release;
	logic hit_stored;
	reg_idx_t hit_idx;
	logic wr_ok;

	pin_sync u_pin_sync (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_pin_n(i_chip_init_pin_n),
		.o_level_n(init_n)
	);

	// low pin, or system reset, holds everything in init
	assign init_hold = i_sys_rst || !init_n;

	init_interval #(
		.CYCLES(INIT_CYCLES)
	) u_interval (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_hold(init_hold),
		.o_done(interval_done)
	);

	// next state
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_HOLD: begin
				if (!init_hold) begin
					state_d = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (interval_done) begin
					state_d = ST_RUN;
				end
			end
			ST_RUN: begin
				state_d = ST_RUN;
			end
			default: begin
				state_d = ST_HOLD;
			end
		endcase
		// a new assertion aborts whatever was going on
		if (init_hold) begin
			state_d = ST_HOLD;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			state_q <= ST_HOLD;
		end else begin
			state_q <= state_d;
		end
	end

	// one-hot state decode shared by the fetch and run logic
	assign in_wait = (state_q == ST_WAIT);
	assign in_run = (state_q == ST_RUN);
	assign boot_addr = phys_addr(regs_q[RI_CODE_SEG], regs_q[RI_IP]);

	// first fetch pulse, once per release; the flag stops a second pulse
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			fetch_start_q <= 1'b0;
			fetch_issued_q <= 1'b0;
		end else begin
			fetch_start_q <= in_wait && interval_done && !init_hold && !fetch_issued_q;
			fetch_issued_q <= init_hold ? 1'b0 : (fetch_issued_q || fetch_start_q);
		end
	end

	// boot address follows the code segment and pointer registers
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			fetch_addr_q <= 20'h00000;
		end else begin
			fetch_addr_q <= boot_addr;
		end
	end

	// only the run state lets the core fetch or drive the bus
	assign o_run = in_run && !init_hold;
	assign o_bus_en = o_run;
	assign o_fetch_start = fetch_start_q;
	assign o_fetch_addr = fetch_addr_q;

	// byte address to register index
	assign rel_addr = i_req.addr - `RIS_OFS_BASE;
	assign in_range = !rel_addr[0] && (rel_addr[7:1] < 7'(RI_RELOC));
	assign hit_reloc = (i_req.addr == `RIS_OFS_RELOC);
	assign hit_release = (i_req.addr == `RIS_OFS_RELEASE);
	assign hit_stored = in_range || hit_reloc;
	assign hit_idx = hit_reloc ? RI_RELOC : reg_idx_t'(rel_addr[6:1]);

	// writes during init would fight the reset load, so they are dropped
	assign wr_ok = i_req.wr && hit_stored && !init_hold;

	// per-register load controls; reset load wins, since writes are dropped while held
	for (genvar g = 0; g < NREG; g++) begin : g_load
		assign load_rst[g] = init_hold && has_reset(reg_idx_t'(g));
		assign load_wr[g] = wr_ok && (hit_idx == reg_idx_t'(g));
	end

	// register file: reset load while held, port writes otherwise
	always_ff @(posedge i_clk) begin
		for (int i = 0; i < NREG; i++) begin
			if (load_rst[i]) begin
				regs_q[i] <= reset_val(reg_idx_t'(i));
			end else if (load_wr[i]) begin
				regs_q[i] <= i_req.wdata;
			end
		end
	end

	// read data stands for one cycle after the strobe, zero otherwise
	always_comb begin
		rdata_d = 16'h0000;
		if (i_req.rd) begin
			if (hit_release) begin
				// lower byte undefined, reads as zero
				rdata_d = {REVISION, 8'h00};
			end else if (hit_stored) begin
				rdata_d = regs_q[hit_idx];
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			rdata_q <= 16'h0000;
		end else begin
			rdata_q <= rdata_d;
		end
	end

	assign o_rdata = rdata_q;

	// core state
	assign o_cpu.status_word = regs_q[RI_FLAGS];
	assign o_cpu.code_segment = regs_q[RI_CODE_SEG];
	assign o_cpu.instruction_pointer = regs_q[RI_IP];
	assign o_cpu.data_segment = regs_q[RI_DATA_SEG];
	assign o_cpu.extra_segment = regs_q[RI_EXTRA_SEG];
	assign o_cpu.stack_segment = regs_q[RI_STACK_SEG];

	// block placement and upper select decode
	assign reloc_word = regs_q[RI_RELOC];
	assign upper_sel_word = regs_q[RI_UPPER_SEL];
	// low eight base bits are always zero, so the block sits on a 256-byte boundary
	assign o_map.block_base = {
		reloc_word[`RIS_RELOC_BASE_MSB:`RIS_RELOC_BASE_LSB], 8'h00
	};
	assign o_map.block_in_memory = reloc_word[`RIS_RELOC_MEM_BIT];
	assign o_map.int_slave_mode = reloc_word[`RIS_RELOC_SLAVE_BIT];
	assign o_map.upper_ready_ignored = upper_sel_word[`RIS_UPPER_RDY_BIT];
	assign o_map.upper_wait_states =
		upper_sel_word[`RIS_UPPER_WAIT_MSB:`RIS_UPPER_WAIT_LSB];

	// gpio and interrupt controller views
	assign o_gpio_direction_hi = regs_q[RI_GPIO_DIR_HI];
	assign o_gpio_direction_lo = regs_q[RI_GPIO_DIR_LO];
	assign o_gpio_function_hi = regs_q[RI_GPIO_FN_HI];
	assign o_gpio_function_lo = regs_q[RI_GPIO_FN_LO];
	assign o_int_mask_bits = regs_q[RI_INT_MASK];
	assign o_priority_threshold = regs_q[RI_PRI_THR];

endmodule : reset_init_state

// [dv/board_reset.sv]
// Purpose: board reset circuit driving the chip init pin
// Assumes: push-pull driver, so the pin is never left floating
// Notes: i_hold lets the bench re-initialise mid-run
module board_reset #(
	parameter int PWRUP = 8
) (
	// clock
	input wire logic i_clk,
	// bench command
	input wire logic i_hold,
	// chip init pin
	output logic o_pin_n
);
	logic [7:0] pwr_q = 8'h00;
	always_ff @(posedge i_clk) begin
		if (pwr_q < 8'(PWRUP)) begin
			pwr_q <= pwr_q + 8'h01;
		end
	end
	// low through power-up and whenever asked
	assign o_pin_n = (pwr_q >= 8'(PWRUP)) && !i_hold;
endmodule : board_reset

// [dv/reset_init_state_monitor.sv]
// Purpose: assertions on the reset and initialization block
// Assumes: one clock, synchronous active-high reset
// Notes: interval window allows for the two-flop pin sync
module reset_init_state_monitor #(
	parameter int INIT_CYCLES = 16
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	input wire logic i_chip_init_pin_n,
	// execution control
	input wire logic o_run,
	input wire logic o_bus_en,
	input wire logic o_fetch_start,
	input wire logic [19:0] o_fetch_addr,
	// register state
	input ris_pkg::cpu_state_t o_cpu,
	input ris_pkg::map_cfg_t o_map,
	input wire logic [15:0] o_gpio_direction_hi,
	input wire logic [15:0] o_gpio_direction_lo,
	input wire logic [15:0] o_gpio_function_hi,
	input wire logic [15:0] o_gpio_function_lo,
	input wire logic [15:0] o_int_mask_bits,
	input wire logic [15:0] o_priority_threshold
);
	import ris_pkg::*;
	localparam int LO = INIT_CYCLES + 1;
	localparam int HI = INIT_CYCLES + 6;
	// cycles spent with the pin high but not yet running
	logic [7:0] wait_q;
	logic [7:0] wait_d;
	assign wait_d = (!i_chip_init_pin_n || o_run) ? 8'h00 : wait_q + 8'h01;
	always_ff @(posedge i_clk) begin
		wait_q <= i_sys_rst ? 8'h00 : wait_d;
	end
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	// three samples low: the synchroniser has surely passed it
	sequence held_s;
		!i_chip_init_pin_n [*3];
	endsequence
	sequence start_s;
		o_fetch_start ##1 !o_fetch_start;
	endsequence
	run_bus_tie_a: assert property (o_bus_en == o_run)
		else $error("bus enable differs from run");
	hold_stops_run_a: assert property (held_s |-> !o_run)
		else $error("running while init held");
	fetch_gate_a: assert property (o_fetch_start |-> o_run)
		else $error("fetch start while halted");
	fetch_once_a: assert property ($rose(o_run) |-> start_s)
		else $error("fetch start not one pulse at run");
	fetch_addr_a: assert property (o_fetch_start |-> o_fetch_addr == 20'hffff0)
		else $error("first fetch not at boot address");
	interval_len_a: assert property ($rose(o_run) |-> wait_q >= 8'(LO) && wait_q <= 8'(HI))
		else $error("interval before run has wrong length");
	interval_bound_a: assert property (wait_q <= 8'(HI))
		else $error("run never started after release");
	cpu_reset_a: assert property (held_s |=> o_cpu == {16'hf002, 16'hffff, 64'h0})
		else $error("cpu state not at reset values");
	map_reset_a: assert property (held_s |=> o_map == {20'h0ff00, 5'b00011})
		else $error("map config not at reset values");
	port_reset_a: assert property (held_s |=> {o_gpio_direction_hi, o_gpio_direction_lo,
		o_gpio_function_hi, o_gpio_function_lo, o_int_mask_bits, o_priority_threshold}
		== {16'hffff, 16'hfc0f, 32'h0, 16'h07fd, 16'h0007})
		else $error("port and interrupt outputs not at reset values");
endmodule : reset_init_state_monitor

bind reset_init_state reset_init_state_monitor #(.INIT_CYCLES(INIT_CYCLES)) u_mon (.*);

// [dv/reset_init_state_tb_top.sv]
// Purpose: self-checking bench for the reset and initialization block
// Assumes: board model drives the chip init pin
// Notes: short interval keeps the run brief
module reset_init_state_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import ris_pkg::*;
	localparam int INIT = 4;
	logic i_clk = 1'b0;
	logic i_sys_rst = 1'b1;
	logic hold = 1'b0;
	logic pin_n;
	reg_req_t i_req = '0;
	logic [15:0] o_rdata;
	logic o_run;
	logic o_fetch_start;
	logic [19:0] o_fetch_addr;
	map_cfg_t o_map;
	int mismatches = 0;
	int num_checks = 0;
	logic [15:0] rst_tbl [32] = '{16'hf002, 16'h0000, 16'hffff, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'hf03b, 16'h0000, 16'h0000, 16'hffff, 16'h0000, 16'hfc0f,
		16'h0000, 16'h001f, 16'h000f, 16'h000f, 16'h000f, 16'h000f, 16'h000f, 16'h000f,
		16'h000f, 16'h000f, 16'h000f, 16'h0000, 16'h0007, 16'h07fd, 16'h0000, 16'h0000,
		16'hfff9, 16'hfff9};
	// revision value is arbitrary
	reset_init_state #(.INIT_CYCLES(INIT), .REVISION(8'h3c)) i_dut (
		.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_chip_init_pin_n(pin_n), .i_req(i_req),
		.o_rdata(o_rdata), .o_run(o_run), .o_bus_en(), .o_fetch_start(o_fetch_start),
		.o_fetch_addr(o_fetch_addr), .o_cpu(), .o_map(o_map), .o_gpio_direction_hi(),
		.o_gpio_direction_lo(), .o_gpio_function_hi(), .o_gpio_function_lo(),
		.o_int_mask_bits(), .o_priority_threshold());
	board_reset #(.PWRUP(12)) i_board (.i_clk(i_clk), .i_hold(hold), .o_pin_n(pin_n));
	always #2 i_clk = ~i_clk;
	task chk(input logic [19:0] got, input logic [19:0] exp);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge i_clk);
		i_req <= '{a, d, 1'b1, 1'b0};
		@(posedge i_clk);
		i_req.wr <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, input logic [19:0] exp);
		@(posedge i_clk);
		i_req <= '{a, 16'h0000, 1'b0, 1'b1};
		@(posedge i_clk);
		i_req.rd <= 1'b0;
		#1 chk({4'h0, o_rdata}, exp);
	endtask : rd
	// bounded wait for run; checks the first fetch
	task wait_run(input logic timed);
		int n;
		n = 0;
		while (o_run !== 1'b1 && n < 100) begin
			@(posedge i_clk);
			#1 n++;
		end
		if (timed) chk(20'(n >= INIT + 1 && n <= INIT + 6), 20'h1);
		chk(20'(o_fetch_start), 20'h1);
		chk(o_fetch_addr, 20'hffff0);
	endtask : wait_run
	task pulse(input int len);
		@(posedge i_clk);
		hold <= 1'b1;
		repeat (len) @(posedge i_clk);
		hold <= 1'b0;
	endtask : pulse
	task check_table(input logic keep);
		for (int i = 0; i < 32; i++) begin
			if (i != 9 || keep) rd(8'(2 * i), {4'h0, (i == 9) ? 16'h123d : rst_tbl[i]});
		end
	endtask : check_table
	task test_done();
		$display("checks=%0d mismatches=%0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : test_done
	initial begin
		repeat (4) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		#1 chk({19'h0, o_run}, 20'h0);
		wait_run(1'b0);
		$display("test power_up done");
		check_table(1'b0);
		rd(8'hfe, 20'h020ff);
		rd(8'h80, 20'h0);
		chk(o_map.block_base, 20'h0ff00);
		$display("test reset_values done");
		for (int i = 0; i < 32; i++) wr(8'(2 * i), 16'h1234 ^ 16'(i));
		wr(8'hfe, 16'h0123);
		rd(8'h00, 20'h01234);
		rd(8'hfe, 20'h00123);
		@(posedge i_clk);
		hold <= 1'b1;
		repeat (4) @(posedge i_clk);
		wr(8'h00, 16'h5555);
		rd(8'h00, 20'h0f002);
		hold <= 1'b0;
		wait_run(1'b1);
		check_table(1'b1);
		rd(8'hfe, 20'h020ff);
		rd(8'hf4, 20'h03c00);
		$display("test reinit done");
		pulse(4);
		repeat (3) @(posedge i_clk);
		pulse(4);
		#1 chk({19'h0, o_run}, 20'h0);
		wait_run(1'b1);
		$display("test abort_wait done");
		@(posedge i_clk);
		i_sys_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		#1 chk({19'h0, o_run}, 20'h0);
		wait_run(1'b1);
		$display("test mid_reset done");
		test_done();
	end
	initial begin
		repeat (20000) @(posedge i_clk);
		mismatches++;
		test_done();
	end
endmodule : reset_init_state_tb_top
